// ### bench/output_mode_loop_regs_bench.sv
// Self-checking bench for the output mode, drive swing and loop-through registers.
// Assumes the constants header and the package are compiled ahead of this file.
`timescale 1ns/10ps
`include "output_mode_loop_params.svh"

module output_mode_loop_regs_bench
  import output_mode_loop_pkg::*;
;
  logic       ref_clk;
  logic       nrst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [1:0] mode_strap_pin;
  logic       map_strap_pin;
  logic       map_select;
  out_mode_e  out_mode;
  logic       dual_output;
  logic       swap_ports;
  logic       replicate_output;
  logic [1:0] drive_swing_code;
  logic       loop_route_b;
  logic       field_sel_a;
  logic       field_sel_b;
  logic       loop_select_mismatch;
  logic       loop_driver_enable;
  int         bad_count;
  int         samples_checked;
  int         cycles;

  output_mode_loop_regs u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mode_strap_pin(mode_strap_pin), .map_strap_pin(map_strap_pin),
    .map_select(map_select), .out_mode(out_mode), .dual_output(dual_output),
    .swap_ports(swap_ports), .replicate_output(replicate_output),
    .drive_swing_code(drive_swing_code), .loop_route_b(loop_route_b),
    .field_sel_a(field_sel_a), .field_sel_b(field_sel_b),
    .loop_select_mismatch(loop_select_mismatch), .loop_driver_enable(loop_driver_enable)
  );

  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;

  // Hang guard, well above the roughly one hundred cycles the scenarios need
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      $display("unexpected at %0t: run did not finish", $time);
      conclude();
    end
  end

  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp8

  task automatic cmp1(input logic got, input logic exp, input string what);
    cmp8({7'h00, got}, {7'h00, exp}, what);
  endtask : cmp1

  // Straps are only sampled at the first edge after release, so set them with reset low
  task automatic apply_reset(input logic [1:0] ms, input logic mp);
    @(posedge ref_clk);
    nrst           <= 1'b0;
    mode_strap_pin <= ms;
    map_strap_pin  <= mp;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : apply_reset

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    cmp8(reg_rdata, exp, "read data");
  endtask : rd

  // Derived outputs lag the register by one edge
  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic strap_load();
    apply_reset(2'h2, 1'b1);
    cmp8({6'h00, out_mode}, 8'h02, "strapped mode");
    cmp1(map_select, 1'b1, "strap map select");
    rd(`OML_ADDR_MODE, 8'h82);
    rd(`OML_ADDR_SWING, 8'h00);
    rd(`OML_ADDR_LOOP_A, 8'h00);
    rd(`OML_ADDR_LOOP_EN, 8'h00);
    cmp1(loop_driver_enable, 1'b0, "driver after reset");
    apply_reset(2'h1, 1'b0);
    rd(`OML_ADDR_MODE, 8'h01);
    cmp1(swap_ports, 1'b1, "strapped swap");
    cmp1(map_select, 1'b0, "strap map select low");
  endtask : strap_load

  task automatic mode_decode();
    for (int i = 0; i < 4; i++)
    begin
      wr(`OML_ADDR_MODE, 8'(i));
      settle();
      cmp8({6'h00, out_mode}, 8'(i), "mode");
      cmp1(dual_output, i < 2, "dual");
      cmp1(swap_ports, i == 1, "swap");
      cmp1(replicate_output, i == 3, "replicate");
      rd(`OML_ADDR_MODE, 8'(i));
    end
  endtask : mode_decode

  task automatic map_override();
    wr(`OML_ADDR_MODE, 8'h60);
    settle();
    cmp1(map_select, 1'b1, "override high");
    wr(`OML_ADDR_MODE, 8'h40);
    settle();
    cmp1(map_select, 1'b0, "override low");
    wr(`OML_ADDR_MODE, 8'h20);
    settle();
    cmp1(map_select, 1'b0, "bit without override");
    // Strap bit is read-only and still shows the low strap
    wr(`OML_ADDR_MODE, 8'hFF);
    rd(`OML_ADDR_MODE, 8'h63);
  endtask : map_override

  task automatic swing_codes();
    for (int i = 0; i < 4; i++)
    begin
      wr(`OML_ADDR_SWING, 8'(i));
      settle();
      cmp8({6'h00, drive_swing_code}, 8'(i), "swing");
    end
    wr(`OML_ADDR_SWING, 8'hFC);
    rd(`OML_ADDR_SWING, 8'h00);
    // Write then read of the same register returns the new value
    wr(`OML_ADDR_SWING, 8'h02);
    rd(`OML_ADDR_SWING, 8'h02);
  endtask : swing_codes

  task automatic loop_select();
    wr(`OML_ADDR_LOOP_B, 8'h02);
    settle();
    cmp1(field_sel_a, 1'b1, "field port a");
    cmp1(loop_route_b, 1'b0, "source port a");
    cmp1(loop_select_mismatch, 1'b0, "match a");
    cmp1(loop_driver_enable, 1'b0, "select alone");
    wr(`OML_ADDR_LOOP_A, 8'hFF);
    wr(`OML_ADDR_LOOP_B, 8'hFF);
    settle();
    cmp1(loop_route_b, 1'b1, "source port b");
    cmp1(field_sel_a, 1'b0, "field both a");
    cmp1(field_sel_b, 1'b0, "field both b");
    cmp1(loop_select_mismatch, 1'b1, "mismatch");
    rd(`OML_ADDR_LOOP_A, 8'h80);
    rd(`OML_ADDR_LOOP_B, 8'h06);
    wr(`OML_ADDR_LOOP_B, 8'h04);
    settle();
    cmp1(field_sel_b, 1'b1, "field port b");
    cmp1(loop_select_mismatch, 1'b0, "match b");
    wr(`OML_ADDR_LOOP_EN, 8'hFF);
    settle();
    cmp1(loop_driver_enable, 1'b1, "driver on");
    rd(`OML_ADDR_LOOP_EN, 8'h08);
    wr(`OML_ADDR_LOOP_EN, 8'hF7);
    settle();
    cmp1(loop_driver_enable, 1'b0, "driver off");
    // Unmapped place: write dropped, read returns zero
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00);
  endtask : loop_select

  // Main sequence
  initial
  begin
    ref_clk        = 1'b0;
    nrst           = 1'b0;
    reg_addr       = 8'h00;
    reg_wdata      = 8'h00;
    reg_wr         = 1'b0;
    reg_rd         = 1'b0;
    mode_strap_pin = 2'h0;
    map_strap_pin  = 1'b0;
    bad_count       = 0;
    samples_checked = 0;
    cycles          = 0;
    strap_load();
    mode_decode();
    map_override();
    swing_codes();
    loop_select();
    conclude();
  end
endmodule : output_mode_loop_regs_bench

// ### hdl/output_mode_loop_params.svh
// Offsets, field positions, reset values and masks of the output mode and loop-through registers.
// Assumes an 8-bit register port with byte-wide data and byte addresses.
`ifndef OUTPUT_MODE_LOOP_PARAMS_SVH
`define OUTPUT_MODE_LOOP_PARAMS_SVH

// Register byte addresses
`define OML_ADDR_MODE     8'h49
`define OML_ADDR_SWING    8'h4B
`define OML_ADDR_LOOP_A   8'h52
`define OML_ADDR_LOOP_EN  8'h56
`define OML_ADDR_LOOP_B   8'h57

// Field positions
`define OML_BIT_STRAP     7
`define OML_BIT_OVERRIDE  6
`define OML_BIT_MAP_REG   5
`define OML_BIT_LOOP_SRC  7
`define OML_BIT_LOOP_EN   3

// Implemented bits of each register; everything else reads zero
`define OML_MASK_MODE     8'hE3
`define OML_MASK_SWING    8'h03
`define OML_MASK_LOOP_A   8'h80
`define OML_MASK_LOOP_EN  8'h08
`define OML_MASK_LOOP_B   8'h06

// Reset values
`define OML_RST_BIT       1'h0
`define OML_RST_FIELD     2'h0
`define OML_RST_BYTE      8'h00

`endif

// ### hdl/output_mode_loop_pkg.sv
// Types shared by the output mode and loop-through register group.
// Assumes the constants header is included by the design file that imports this package.
package output_mode_loop_pkg;

  // Display output port arrangement
  typedef enum logic [1:0] {
    MODE_DUAL      = 2'b00,
    MODE_DUAL_SWAP = 2'b01,
    MODE_SINGLE    = 2'b10,
    MODE_REPLICATE = 2'b11
  } out_mode_e;

  // Second loop-through source field codes
  typedef enum logic [1:0] {
    FIELD_NONE   = 2'b00,
    FIELD_PORT_A = 2'b01,
    FIELD_PORT_B = 2'b10,
    FIELD_BOTH   = 2'b11
  } loop_field_e;

endpackage : output_mode_loop_pkg

// ### hdl/output_mode_loop_regs.sv
// Output mode, drive swing and loop-through select registers of the deserializer.
// Assumes a single-cycle strobe register port and strap inputs stable around reset release.
`timescale 1ns/10ps
`include "output_mode_loop_params.svh"

module output_mode_loop_regs
  import output_mode_loop_pkg::*;
(
  input  wire logic        ref_clk,            // 250 MHz clock
  input  wire logic        nrst,               // Asynchronous reset, active low
  input  wire logic [7:0]  reg_addr,           // Register byte address
  input  wire logic [7:0]  reg_wdata,          // Write data
  input  wire logic        reg_wr,             // Write strobe
  input  wire logic        reg_rd,             // Read strobe
  output logic      [7:0]  reg_rdata,          // Read data, cycle after the strobe
  input  wire logic [1:0]  mode_strap_pin,     // Port mode strap option
  input  wire logic        map_strap_pin,      // Pixel-mapping strap level
  output logic             map_select,         // Effective pixel-mapping select
  output out_mode_e        out_mode,           // Decoded output port mode
  output logic             dual_output,        // Both ports carry distinct data
  output logic             swap_ports,         // Dual output with ports exchanged
  output logic             replicate_output,   // Same data on both ports
  output logic      [1:0]  drive_swing_code,   // Output swing setting
  output logic             loop_route_b,       // Loop output fed from input port b
  output logic             field_sel_a,        // Second field picks input port a
  output logic             field_sel_b,        // Second field picks input port b
  output logic             loop_select_mismatch, // Source bit and field disagree
  output logic             loop_driver_enable  // Loop-through driver on
);

  // Register state
  logic        strap_loaded;
  logic        strap_level;
  logic        map_override;
  logic        map_reg_bit;
  logic [1:0]  output_port_mode_field;
  logic [1:0]  swing_field;
  logic        loop_source_bit;
  logic        loop_en_bit;
  loop_field_e loop_source_field;

  // Write decodes
  logic        wr_mode;
  logic        wr_swing;
  logic        wr_loop_a;
  logic        wr_loop_en;
  logic        wr_loop_b;

  // Implemented-bit mask of an address; unmapped addresses have none
  function automatic logic [7:0] bit_mask(input logic [7:0] addr);
    begin
      unique case (addr)
        `OML_ADDR_MODE:    bit_mask = `OML_MASK_MODE;
        `OML_ADDR_SWING:   bit_mask = `OML_MASK_SWING;
        `OML_ADDR_LOOP_A:  bit_mask = `OML_MASK_LOOP_A;
        `OML_ADDR_LOOP_EN: bit_mask = `OML_MASK_LOOP_EN;
        `OML_ADDR_LOOP_B:  bit_mask = `OML_MASK_LOOP_B;
        default:           bit_mask = `OML_RST_BYTE;
      endcase
    end
  endfunction : bit_mask

  // Field code decode, shared by the outputs and the mismatch check
  function automatic logic field_is(input loop_field_e code, input loop_field_e want);
    begin
      field_is = (code == want);
    end
  endfunction : field_is

  assign wr_mode    = reg_wr && (reg_addr == `OML_ADDR_MODE);
  assign wr_swing   = reg_wr && (reg_addr == `OML_ADDR_SWING);
  assign wr_loop_a  = reg_wr && (reg_addr == `OML_ADDR_LOOP_A);
  assign wr_loop_en = reg_wr && (reg_addr == `OML_ADDR_LOOP_EN);
  assign wr_loop_b  = reg_wr && (reg_addr == `OML_ADDR_LOOP_B);

  // Strap capture at the first edge after release; reset itself only loads constants
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_loaded <= `OML_RST_BIT;
      strap_level  <= `OML_RST_BIT;
    end
    else if (!strap_loaded)
    begin
      strap_loaded <= 1'b1;
      strap_level  <= map_strap_pin;
    end
  end

  // Mapping override and register bit
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      map_override <= `OML_RST_BIT;
      map_reg_bit  <= `OML_RST_BIT;
    end
    else if (wr_mode)
    begin
      map_override <= reg_wdata[`OML_BIT_OVERRIDE];
      map_reg_bit  <= reg_wdata[`OML_BIT_MAP_REG];
    end
  end

  // Port mode field; the strap load wins over a write that races it
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      output_port_mode_field <= `OML_RST_FIELD;
    end
    else if (!strap_loaded)
    begin
      output_port_mode_field <= mode_strap_pin;
    end
    else if (wr_mode)
    begin
      output_port_mode_field <= reg_wdata[1:0];
    end
  end

  // Drive swing code
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      swing_field <= `OML_RST_FIELD;
    end
    else if (wr_swing)
    begin
      swing_field <= reg_wdata[1:0];
    end
  end

  // Loop-through source bit, driver enable and second source field
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      loop_source_bit   <= `OML_RST_BIT;
      loop_en_bit       <= `OML_RST_BIT;
      loop_source_field <= FIELD_NONE;
    end
    else
    begin
      if (wr_loop_a)
      begin
        loop_source_bit <= reg_wdata[`OML_BIT_LOOP_SRC];
      end
      if (wr_loop_en)
      begin
        loop_en_bit <= reg_wdata[`OML_BIT_LOOP_EN];
      end
      if (wr_loop_b)
      begin
        loop_source_field <= loop_field_e'(reg_wdata[2:1]);
      end
    end
  end

  // Read data for one cycle after the strobe; reserved and unmapped bits are zero
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= `OML_RST_BYTE;
    end
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `OML_ADDR_MODE:    reg_rdata <= {strap_level, map_override, map_reg_bit, 3'h0, output_port_mode_field};
        `OML_ADDR_SWING:   reg_rdata <= {6'h00, swing_field};
        `OML_ADDR_LOOP_A:  reg_rdata <= {loop_source_bit, 7'h00};
        `OML_ADDR_LOOP_EN: reg_rdata <= {4'h0, loop_en_bit, 3'h0};
        `OML_ADDR_LOOP_B:  reg_rdata <= {5'h00, loop_source_field, 1'h0};
        default:           reg_rdata <= `OML_RST_BYTE;
      endcase
    end
    else
    begin
      reg_rdata <= `OML_RST_BYTE;
    end
  end

  // Mapping select output; registered so the datapath sees a clean level
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      map_select <= `OML_RST_BIT;
    end
    else
    begin
      map_select <= map_override ? map_reg_bit : strap_level;
    end
  end

  // Port mode decode
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_mode         <= MODE_DUAL;
      dual_output      <= 1'b0;
      swap_ports       <= 1'b0;
      replicate_output <= 1'b0;
    end
    else
    begin
      out_mode         <= out_mode_e'(output_port_mode_field);
      dual_output      <= (output_port_mode_field == MODE_DUAL) ||
                          (output_port_mode_field == MODE_DUAL_SWAP);
      swap_ports       <= (output_port_mode_field == MODE_DUAL_SWAP);
      replicate_output <= (output_port_mode_field == MODE_REPLICATE);
    end
  end

  // Swing code output
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      drive_swing_code <= `OML_RST_FIELD;
    end
    else
    begin
      drive_swing_code <= swing_field;
    end
  end

  // Loop-through routing; the driver follows only its own enable, never the select
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      loop_route_b         <= 1'b0;
      field_sel_a          <= 1'b0;
      field_sel_b          <= 1'b0;
      loop_select_mismatch <= 1'b0;
      loop_driver_enable   <= 1'b0;
    end
    else
    begin
      loop_route_b         <= loop_source_bit;
      field_sel_a          <= field_is(loop_source_field, FIELD_PORT_A);
      field_sel_b          <= field_is(loop_source_field, FIELD_PORT_B);
      // Flag only; software owns keeping the two selects in step
      loop_select_mismatch <= loop_source_bit ? !field_is(loop_source_field, FIELD_PORT_B)
                                              : !field_is(loop_source_field, FIELD_PORT_A);
      loop_driver_enable   <= loop_en_bit;
    end
  end

  // Checks on the register group
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  a_strap_capture: assert property ($rose(strap_loaded) |-> strap_level == $past(map_strap_pin))
    else $error("strap level not captured at release");

  a_strap_readback: assert property (reg_rd && reg_addr == `OML_ADDR_MODE
    |=> reg_rdata[`OML_BIT_STRAP] == $past(strap_level))
    else $error("strap status bit wrong on read");

  a_strap_select: assert property (strap_loaded && !map_override |=> map_select == $past(strap_level))
    else $error("mapping select not following strap");

  a_override_select: assert property (map_override |=> map_select == $past(map_reg_bit))
    else $error("mapping select not following register bit");

  a_mode_decode: assert property (strap_loaded |=> swap_ports == ($past(output_port_mode_field) == 2'b01)
    && replicate_output == ($past(output_port_mode_field) == 2'b11)
    && dual_output == ($past(output_port_mode_field[1]) == 1'b0))
    else $error("port mode decode wrong");

  a_mode_strap_load: assert property ($rose(strap_loaded) |-> output_port_mode_field == $past(mode_strap_pin))
    else $error("port mode not loaded from strap");

  a_swing_write: assert property (wr_swing |=> ##1 drive_swing_code == $past(reg_wdata[1:0], 2))
    else $error("swing code not taken from write");

  a_loop_source: assert property (wr_loop_a |=> ##1 loop_route_b == $past(reg_wdata[`OML_BIT_LOOP_SRC], 2))
    else $error("loop source routing wrong");

  a_driver_enable: assert property (wr_loop_en |=> ##1 loop_driver_enable == $past(reg_wdata[`OML_BIT_LOOP_EN], 2))
    else $error("loop driver enable not taken from write");

  a_driver_needs_en: assert property (!loop_en_bit |=> !loop_driver_enable)
    else $error("loop driver on without enable");

  a_field_decode: assert property (wr_loop_b |=> ##1 field_sel_a == ($past(reg_wdata[2:1], 2) == 2'b01)
    && field_sel_b == ($past(reg_wdata[2:1], 2) == 2'b10))
    else $error("second loop field decode wrong");

  a_reserved_zero: assert property (reg_rd |=> (reg_rdata & ~bit_mask($past(reg_addr))) == 8'h00)
    else $error("reserved bits not read as zero");

  // Write paths and hold checks; swing, loop source and loop enable move only on their own write, so a stray decode there shows here
  a_strap_hold: assert property (strap_loaded |=> $stable(strap_level))
    else $error("strap level changed after capture");

  a_override_write: assert property (wr_mode |=> map_override == $past(reg_wdata[`OML_BIT_OVERRIDE]))
    else $error("override bit not taken from write");

  a_map_bit_write: assert property (wr_mode |=> map_reg_bit == $past(reg_wdata[`OML_BIT_MAP_REG]))
    else $error("mapping register bit not taken from write");

  a_mode_copy: assert property (strap_loaded |=> out_mode == $past(output_port_mode_field))
    else $error("port mode output not following field");

  a_mode_write: assert property (strap_loaded && wr_mode |=> output_port_mode_field == $past(reg_wdata[1:0]))
    else $error("port mode field not taken from write");

  a_swing_hold: assert property (!wr_swing |=> $stable(swing_field))
    else $error("swing code moved without write");

  a_source_hold: assert property (!wr_loop_a |=> $stable(loop_source_bit))
    else $error("loop source moved without write");

  a_enable_hold: assert property (!wr_loop_en |=> $stable(loop_en_bit))
    else $error("loop enable moved without write");

  // Read data must fall back to zero, or a late sample would see stale bits
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");

  // Main scenarios
  c_override_used: cover property (wr_mode && reg_wdata[`OML_BIT_OVERRIDE] ##2 map_select != strap_level);
  c_swing_roundtrip: cover property (wr_swing && reg_wdata[1:0] == 2'h3 ##1 reg_rd && reg_addr == `OML_ADDR_SWING);
  c_loop_port_b: cover property (loop_driver_enable && loop_route_b && field_sel_b && !loop_select_mismatch);
  c_replicate_mode: cover property (replicate_output && !dual_output);
  c_select_no_driver: cover property (field_sel_a && !loop_driver_enable);

endmodule : output_mode_loop_regs
